// [sim/atsc_host_model.sv]
// host cpu model issuing i/o reads and writes on the local bus
`timescale 1ns/1ps
module atsc_host_model (
	input wire logic clk_sys,
	output atsc_pkg::atsc_io_req_t io_req,
	input wire atsc_pkg::atsc_io_rsp_t io_rsp,
	input wire logic kbc_select_n
);
	initial begin
		io_req = '0;
	end

	// one-cycle write strobe; address and data are scrambled once released
	task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
		@(negedge clk_sys);
		io_req = '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(negedge clk_sys);
		io_req = '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
	endtask

	// one-cycle read strobe; answer and keyboard select taken the cycle after
	task automatic io_read(input logic [15:0] addr, output logic [7:0] data,
		output logic ok, output logic sel_n);
		@(negedge clk_sys);
		io_req = '{addr: addr, wdata: 8'h5a, wr: 1'b0, rd: 1'b1};
		@(negedge clk_sys);
		data = io_rsp.rdata;
		ok = io_rsp.rvalid;
		sel_n = kbc_select_n;
		io_req = '{addr: ~addr, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
	endtask
endmodule

// [sim/tb_atsc_top.sv]
// self-checking testbench for the at system control ports
`timescale 1ns/1ps
module tb_atsc_top;
	localparam int DLY = 20;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	atsc_pkg::atsc_io_req_t io_req;
	atsc_pkg::atsc_io_rsp_t io_rsp;
	logic fast_port_enable = 1'b0;
	logic parity_override = 1'b0;
	logic timer2_out = 1'b0;
	logic refresh_cycle = 1'b0;
	logic io_check_n = 1'b1;
	logic parity_err_n = 1'b1;
	logic kbc_reset_cpu_n = 1'b1;
	logic kbc_addr20_force_low_n = 1'b1;
	logic kbc_outbuf_full = 1'b0;
	logic timer2_gate, speaker_data, parity_sample_dis, nmi, addr_bit20_force_low_n;
	logic cpu_reset_out, kbc_select_n, irq1;
	logic [6:0] rtc_index;
	logic [7:0] rd_data;
	logic rd_ok;
	logic rd_sel;
	int n_fail = 0;
	int tests_run = 0;

	always #2 clk_sys = ~clk_sys;

	atsc_top #(.RESET_DELAY_CYC(DLY)) atsc_top_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.io_req(io_req), .io_rsp(io_rsp), .fast_port_enable(fast_port_enable),
		.parity_override(parity_override), .timer2_out(timer2_out),
		.refresh_cycle(refresh_cycle), .io_check_n(io_check_n), .parity_err_n(parity_err_n),
		.kbc_reset_cpu_n(kbc_reset_cpu_n), .kbc_addr20_force_low_n(kbc_addr20_force_low_n),
		.kbc_outbuf_full(kbc_outbuf_full), .timer2_gate(timer2_gate),
		.speaker_data(speaker_data), .parity_sample_dis(parity_sample_dis),
		.rtc_index(rtc_index), .nmi(nmi), .addr_bit20_force_low_n(addr_bit20_force_low_n),
		.cpu_reset_out(cpu_reset_out), .kbc_select_n(kbc_select_n), .irq1(irq1));

	atsc_host_model atsc_host_model_i (.clk_sys(clk_sys), .io_req(io_req), .io_rsp(io_rsp),
		.kbc_select_n(kbc_select_n));

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		check(what, {7'h0, exp}, {7'h0, got});
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		atsc_host_model_i.io_write(a, d);
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		atsc_host_model_i.io_read(a, rd_data, rd_ok, rd_sel);
		chk1("rvalid", 1'b1, rd_ok);
		check("rdata", exp, rd_data);
	endtask

	// single-cycle pulse on an input, applied at the falling edge
	task automatic blip(ref logic sig, input logic act);
		@(negedge clk_sys);
		sig = act;
		@(negedge clk_sys);
		sig = ~act;
	endtask

	// measure delay and width of the programmed cpu reset pulse
	task automatic pulse_check(input logic want);
		int n;
		int w;
		n = 0;
		w = 0;
		while (cpu_reset_out !== 1'b1 && n < DLY + 40) begin
			@(negedge clk_sys);
			n++;
		end
		while (cpu_reset_out === 1'b1 && w < 100) begin
			@(negedge clk_sys);
			w++;
		end
		if (want && (n == DLY + 40 || w == 100)) begin
			chk1("reset pulse bounded", 1'b1, 1'b0);
			report_and_stop();
		end
		if (want) begin
			chk1("reset delay", 1'b1, n >= DLY && n <= DLY + 3);
			chk1("reset width", 1'b1, w * 4 >= 125 && w * 4 <= 150);
		end else begin
			chk1("no reset pulse", 1'b1, n == DLY + 40);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		logic [15:0] kaddr [4];
		kaddr = '{16'h0060, 16'h0062, 16'h0064, 16'h0061};
		repeat (3) @(negedge clk_sys);
		rst_b = 1'b1;
		chk1("nmi", 1'b0, nmi);
		chk1("a20_n", 1'b1, addr_bit20_force_low_n);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h00);
		$display("test reset done");
		timer2_out = 1'b1;
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'hf3);
		chk1("timer2_gate", 1'b1, timer2_gate);
		@(negedge clk_sys);
		chk1("speaker_data", 1'b1, speaker_data);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h23);
		blip(refresh_cycle, 1'b1);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h33);
		blip(refresh_cycle, 1'b1);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h23);
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'h00);
		chk1("timer2_gate", 1'b0, timer2_gate);
		@(negedge clk_sys);
		chk1("speaker_data", 1'b0, speaker_data);
		parity_override = 1'b1;
		blip(parity_err_n, 1'b0);
		chk1("parity_dis", 1'b1, parity_sample_dis);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h20);
		parity_override = 1'b0;
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'h04);
		blip(parity_err_n, 1'b0);
		chk1("parity_dis", 1'b1, parity_sample_dis);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h24);
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'h00);
		blip(parity_err_n, 1'b0);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'ha0);
		wr(atsc_pkg::ADDR_RTC_INDEX, 8'h85);
		repeat (2) @(negedge clk_sys);
		chk1("nmi masked", 1'b0, nmi);
		rdchk(atsc_pkg::ADDR_RTC_INDEX, 8'h05);
		wr(atsc_pkg::ADDR_RTC_INDEX, 8'h05);
		check("rtc_index", 8'h05, {1'b0, rtc_index});
		repeat (2) @(negedge clk_sys);
		chk1("nmi", 1'b1, nmi);
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'h04);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h24);
		chk1("nmi", 1'b0, nmi);
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'h00);
		blip(io_check_n, 1'b0);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h60);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h60);
		chk1("nmi", 1'b1, nmi);
		wr(atsc_pkg::ADDR_SYS_CTRL, 8'h08);
		blip(io_check_n, 1'b0);
		rdchk(atsc_pkg::ADDR_SYS_CTRL, 8'h28);
		chk1("nmi", 1'b0, nmi);
		$display("test system control done");
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h02);
		atsc_host_model_i.io_read(atsc_pkg::ADDR_FAST_PORT, rd_data, rd_ok, rd_sel);
		chk1("rvalid off", 1'b0, rd_ok);
		chk1("a20_n", 1'b1, addr_bit20_force_low_n);
		fast_port_enable = 1'b1;
		rdchk(atsc_pkg::ADDR_FAST_PORT, 8'h00);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h02);
		@(negedge clk_sys);
		chk1("a20_n", 1'b0, addr_bit20_force_low_n);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h03);
		pulse_check(1'b1);
		rdchk(atsc_pkg::ADDR_FAST_PORT, 8'h03);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h03);
		pulse_check(1'b0);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h02);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h03);
		pulse_check(1'b1);
		chk1("a20_n", 1'b0, addr_bit20_force_low_n);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h00);
		@(negedge clk_sys);
		chk1("a20_n", 1'b1, addr_bit20_force_low_n);
		$display("test fast port done");
		kbc_addr20_force_low_n = 1'b0;
		kbc_reset_cpu_n = 1'b0;
		kbc_outbuf_full = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk1("a20_n kbc", 1'b0, addr_bit20_force_low_n);
		chk1("cpu_reset kbc", 1'b1, cpu_reset_out);
		chk1("irq1", 1'b1, irq1);
		kbc_addr20_force_low_n = 1'b1;
		kbc_reset_cpu_n = 1'b1;
		kbc_outbuf_full = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk1("cpu_reset", 1'b0, cpu_reset_out);
		chk1("irq1", 1'b0, irq1);
		foreach (kaddr[i]) begin
			atsc_host_model_i.io_read(kaddr[i], rd_data, rd_ok, rd_sel);
			chk1("kbc_select_n", kaddr[i] == 16'h0061, rd_sel);
		end
		atsc_host_model_i.io_read(16'h0071, rd_data, rd_ok, rd_sel);
		chk1("rvalid unmapped", 1'b0, rd_ok);
		wr(atsc_pkg::ADDR_FAST_PORT, 8'h02);
		@(negedge clk_sys);
		rst_b = 1'b0;
		repeat (3) @(negedge clk_sys);
		rst_b = 1'b1;
		rdchk(atsc_pkg::ADDR_FAST_PORT, 8'h00);
		chk1("a20_n", 1'b1, addr_bit20_force_low_n);
		$display("test keyboard and reset done");
		report_and_stop();
	end
endmodule

// [verilog/atsc_pkg.sv]
// shared constants and types for the at system control ports
// Operation
// - port b bit0 gates timer channel 2
// - port b bit1 gates timer 2 to speaker
// - bit2 or override disables parity sampling
// - bit3 set disables channel check sampling
// - bit4 toggles on each refresh cycle
// - bit5 reads timer channel 2 output
// - channel check sets io status, sticky
// - parity error each clock sets parity status
// - parity status clears when checking disabled
// - index bits 6:0 drive rtc index
// - index bit7 write masks nmi
// - nmi off at reset, else status or
// - fast port answers only when enabled
// - fast port at 92h, resets to 00h
// - fast port bit1 forces addr20 low
// - bit0 rise gives delayed reset pulse
// - one pulse per zero to one change made while no pulse is pending
// - bit0 stays set after programmed reset
// - keyboard reset and a20 merged in
// - kbc select on 60h 62h 64h, irq1
package atsc_pkg;
	localparam logic [15:0] ADDR_KBC_DATA = 16'h0060;
	localparam logic [15:0] ADDR_SYS_CTRL = 16'h0061;
	localparam logic [15:0] ADDR_KBC_AUX = 16'h0062;
	localparam logic [15:0] ADDR_KBC_CMD = 16'h0064;
	localparam logic [15:0] ADDR_RTC_INDEX = 16'h0070;
	localparam logic [15:0] ADDR_FAST_PORT = 16'h0092;
	localparam logic [7:0] FAST_PORT_RESET = 8'h00;
	localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
	localparam logic [6:0] RTC_INDEX_RESET = 7'h00;
	localparam logic NMI_MASK_RESET = 1'b1;
	localparam int SC_TMR_GATE = 0;
	localparam int SC_SPK_DATA = 1;
	localparam int SC_PAR_DIS = 2;
	localparam int SC_CHK_DIS = 3;
	localparam int SC_REFRESH = 4;
	localparam int SC_TMR_OUT = 5;
	localparam int SC_IO_CHK = 6;
	localparam int SC_PAR_CHK = 7;
	localparam int FP_RESET_BIT = 0;
	localparam int FP_A20_BIT = 1;
	localparam int RTC_MASK_BIT = 7;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int RESET_DELAY_PS = 6720000;
	localparam int RESET_PULSE_MIN_PS = 125000;
	localparam int RESET_PULSE_MAX_PS = 150000;
	localparam int RESET_DELAY_CYC = RESET_DELAY_PS / CLK_PERIOD_PS;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESET_PULSE_MAX_CYC = RESET_PULSE_MAX_PS / CLK_PERIOD_PS;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} atsc_io_req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic rvalid;
	} atsc_io_rsp_t;
endpackage

// [verilog/atsc_reset_pulse.sv]
// delayed fixed-width reset pulse generator
`timescale 1ns/1ps
module atsc_reset_pulse #(
	parameter int DELAY_CYC = atsc_pkg::RESET_DELAY_CYC,
	parameter int WIDTH_CYC = atsc_pkg::RESET_PULSE_CYC,
	parameter int CNT_W = 12
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic trigger,
	output logic pulse,
	output logic busy
);
	typedef enum logic [1:0] {ATSC_IDLE, ATSC_WAIT, ATSC_PULSE} atsc_rp_state_t;

	if (DELAY_CYC < 8 || WIDTH_CYC < 8 ||
		DELAY_CYC >= (1 << CNT_W) || WIDTH_CYC >= (1 << CNT_W)) begin : g_chk
		$error("atsc_reset_pulse: counts out of range");
	end

	localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);
	localparam logic [CNT_W-1:0] WIDTH_LAST = CNT_W'(WIDTH_CYC - 1);

	atsc_rp_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic pulse_reg;

	wire logic wait_done = (cnt_reg == DELAY_LAST);
	wire logic pulse_done = (cnt_reg == WIDTH_LAST);

	// delay after the write, then a fixed pulse
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + CNT_W'(1);
		unique case (state_reg)
			ATSC_IDLE: begin
				cnt_next = '0;
				if (trigger) begin
					state_next = ATSC_WAIT;
				end
			end
			ATSC_WAIT: begin
				if (wait_done) begin
					state_next = ATSC_PULSE;
					cnt_next = '0;
				end
			end
			ATSC_PULSE: begin
				if (pulse_done) begin
					state_next = ATSC_IDLE;
					cnt_next = '0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg <= ATSC_IDLE;
			cnt_reg <= '0;
			pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pulse_reg <= (state_next == ATSC_PULSE);
		end
	end

	assign pulse = pulse_reg;
	assign busy = (state_reg != ATSC_IDLE);

	property p_pulse_width;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(pulse_reg) |-> pulse_reg [*8];
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("reset pulse too short");

	property p_pulse_bound;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_reg == ATSC_PULSE) |-> (cnt_reg <= WIDTH_LAST);
	endproperty
	a_pulse_bound: assert property (p_pulse_bound) else $error("reset pulse too long");

	property p_no_early_pulse;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_reg == ATSC_IDLE && trigger) |=> !pulse_reg [*8];
	endproperty
	a_no_early_pulse: assert property (p_no_early_pulse)
		else $error("reset pulse started early");

	c_pulse: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(pulse_reg));
endmodule

// [verilog/atsc_top.sv]
// at system control port, rtc index / nmi mask and fast reset / a20 port
`timescale 1ns/1ps
module atsc_top #(
	parameter int RESET_DELAY_CYC = atsc_pkg::RESET_DELAY_CYC,
	parameter int RESET_PULSE_CYC = atsc_pkg::RESET_PULSE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire atsc_pkg::atsc_io_req_t io_req,
	output atsc_pkg::atsc_io_rsp_t io_rsp,
	input wire logic fast_port_enable,
	input wire logic parity_override,
	input wire logic timer2_out,
	input wire logic refresh_cycle,
	input wire logic io_check_n,
	input wire logic parity_err_n,
	input wire logic kbc_reset_cpu_n,
	input wire logic kbc_addr20_force_low_n,
	input wire logic kbc_outbuf_full,
	output logic timer2_gate,
	output logic speaker_data,
	output logic parity_sample_dis,
	output logic [6:0] rtc_index,
	output logic nmi,
	output logic addr_bit20_force_low_n,
	output logic cpu_reset_out,
	output logic kbc_select_n,
	output logic irq1
);
	if (RESET_PULSE_CYC * atsc_pkg::CLK_PERIOD_PS < atsc_pkg::RESET_PULSE_MIN_PS ||
		RESET_PULSE_CYC * atsc_pkg::CLK_PERIOD_PS > atsc_pkg::RESET_PULSE_MAX_PS ||
		RESET_DELAY_CYC < 8) begin : g_chk
		$error("atsc_top: reset pulse timing out of range");
	end

	logic [3:0] ctrl_reg;
	logic refresh_tgl_reg;
	logic io_chk_reg;
	logic par_chk_reg;
	logic [6:0] rtc_idx_reg;
	logic nmi_mask_reg;
	logic [7:0] fast_port_reg;
	logic nmi_reg;
	logic par_dis_reg;
	logic spk_reg;
	logic a20_n_reg;
	logic cpu_rst_reg;
	logic kbc_sel_n_reg;
	logic irq1_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic fast_pulse;
	logic fast_busy;

	// address decode
	wire logic hit_ctrl = (io_req.addr == atsc_pkg::ADDR_SYS_CTRL);
	wire logic hit_rtc = (io_req.addr == atsc_pkg::ADDR_RTC_INDEX);
	wire logic hit_fast = (io_req.addr == atsc_pkg::ADDR_FAST_PORT) &&
		fast_port_enable;
	wire logic hit_kbc = (io_req.addr == atsc_pkg::ADDR_KBC_DATA) ||
		(io_req.addr == atsc_pkg::ADDR_KBC_AUX) ||
		(io_req.addr == atsc_pkg::ADDR_KBC_CMD);
	wire logic wr_ctrl = io_req.wr && hit_ctrl;
	wire logic wr_rtc = io_req.wr && hit_rtc;
	wire logic wr_fast = io_req.wr && hit_fast;

	// control bits after a write; status bits 7:4 never written
	wire logic [3:0] ctrl_next = wr_ctrl ? io_req.wdata[3:0] : ctrl_reg;
	wire logic par_dis = ctrl_reg[atsc_pkg::SC_PAR_DIS] || parity_override;
	wire logic chk_dis = ctrl_reg[atsc_pkg::SC_CHK_DIS];

	// sticky status: set needs sampling enabled, clear needs it disabled
	wire logic io_chk_next = chk_dis ? 1'b0 : (io_chk_reg || !io_check_n);
	wire logic par_chk_next = par_dis ? 1'b0 : (par_chk_reg || !parity_err_n);

	wire logic [7:0] fast_next = wr_fast ? io_req.wdata : fast_port_reg;
	// only a zero to one change of bit0 arms the pulse
	wire logic fast_arm = wr_fast && io_req.wdata[atsc_pkg::FP_RESET_BIT] &&
		!fast_port_reg[atsc_pkg::FP_RESET_BIT];

	wire logic [7:0] ctrl_view = {par_chk_reg, io_chk_reg, timer2_out, refresh_tgl_reg,
		ctrl_reg};
	wire logic [7:0] rtc_view = {1'b0, rtc_idx_reg};
	wire logic [7:0] rd_mux = hit_ctrl ? ctrl_view :
		hit_rtc ? rtc_view :
		hit_fast ? fast_port_reg : 8'h00;
	wire logic rd_hit = io_req.rd && (hit_ctrl || hit_rtc || hit_fast);

	// merged sources for a20 clamp and cpu reset
	wire logic a20_force = fast_port_reg[atsc_pkg::FP_A20_BIT] ||
		!kbc_addr20_force_low_n;
	wire logic cpu_rst = fast_pulse || !kbc_reset_cpu_n;
	wire logic nmi_next = !nmi_mask_reg && (par_chk_reg || io_chk_reg);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_reg <= atsc_pkg::SYS_CTRL_RESET[3:0];
			io_chk_reg <= 1'b0;
			par_chk_reg <= 1'b0;
			par_dis_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			par_dis_reg <= ctrl_next[atsc_pkg::SC_PAR_DIS] || parity_override;
			io_chk_reg <= io_chk_next;
			par_chk_reg <= par_chk_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			refresh_tgl_reg <= 1'b0;
		end else if (refresh_cycle) begin
			refresh_tgl_reg <= !refresh_tgl_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rtc_idx_reg <= atsc_pkg::RTC_INDEX_RESET;
			nmi_mask_reg <= atsc_pkg::NMI_MASK_RESET;
		end else if (wr_rtc) begin
			rtc_idx_reg <= io_req.wdata[6:0];
			nmi_mask_reg <= io_req.wdata[atsc_pkg::RTC_MASK_BIT];
		end
	end

	// bit0 is left as written, so it still reads 1 after the reset pulse
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			fast_port_reg <= atsc_pkg::FAST_PORT_RESET;
		end else begin
			fast_port_reg <= fast_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			nmi_reg <= 1'b0;
			spk_reg <= 1'b0;
			a20_n_reg <= 1'b1;
			cpu_rst_reg <= 1'b0;
			kbc_sel_n_reg <= 1'b1;
			irq1_reg <= 1'b0;
		end else begin
			nmi_reg <= nmi_next;
			spk_reg <= timer2_out && ctrl_reg[atsc_pkg::SC_SPK_DATA];
			a20_n_reg <= !a20_force;
			cpu_rst_reg <= cpu_rst;
			kbc_sel_n_reg <= !((io_req.rd || io_req.wr) && hit_kbc);
			irq1_reg <= kbc_outbuf_full;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rd_mux;
			rvalid_reg <= rd_hit;
		end
	end

	atsc_reset_pulse #(
		.DELAY_CYC(RESET_DELAY_CYC),
		.WIDTH_CYC(RESET_PULSE_CYC),
		.CNT_W(12)
	) u_reset_pulse (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.trigger(fast_arm),
		.pulse(fast_pulse),
		.busy(fast_busy)
	);

	assign timer2_gate = ctrl_reg[atsc_pkg::SC_TMR_GATE];
	assign speaker_data = spk_reg;
	assign parity_sample_dis = par_dis_reg;
	assign rtc_index = rtc_idx_reg;
	assign nmi = nmi_reg;
	assign addr_bit20_force_low_n = a20_n_reg;
	assign cpu_reset_out = cpu_rst_reg;
	assign kbc_select_n = kbc_sel_n_reg;
	assign irq1 = irq1_reg;
	assign io_rsp.rdata = rdata_reg;
	assign io_rsp.rvalid = rvalid_reg;

	property p_gate_write;
		@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl |=> timer2_gate == $past(io_req.wdata[0]);
	endproperty
	a_gate_write: assert property (p_gate_write) else $error("timer gate not written");

	property p_speaker;
		@(posedge clk_sys) disable iff (!rst_b)
		!ctrl_reg[atsc_pkg::SC_SPK_DATA] |=> !speaker_data;
	endproperty
	a_speaker: assert property (p_speaker) else $error("speaker passes while gated");

	property p_parity_off;
		@(posedge clk_sys) disable iff (!rst_b)
		(parity_override || ctrl_reg[atsc_pkg::SC_PAR_DIS]) |=> !par_chk_reg;
	endproperty
	a_parity_off: assert property (p_parity_off)
		else $error("parity status with sampling off");

	property p_io_check_set;
		@(posedge clk_sys) disable iff (!rst_b)
		(!io_check_n && !chk_dis) |=> io_chk_reg ##1 (io_chk_reg || $past(chk_dis));
	endproperty
	a_io_check_set: assert property (p_io_check_set) else $error("io check not sticky");

	property p_parity_set;
		@(posedge clk_sys) disable iff (!rst_b)
		(!parity_err_n && !par_dis) |=> par_chk_reg;
	endproperty
	a_parity_set: assert property (p_parity_set) else $error("parity error missed");

	property p_refresh;
		@(posedge clk_sys) disable iff (!rst_b)
		refresh_cycle |=> refresh_tgl_reg != $past(refresh_tgl_reg);
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh bit did not toggle");

	property p_nmi_mask;
		@(posedge clk_sys) disable iff (!rst_b)
		nmi_mask_reg |=> !nmi;
	endproperty
	a_nmi_mask: assert property (p_nmi_mask) else $error("nmi while masked");

	property p_nmi_follow;
		@(posedge clk_sys) disable iff (!rst_b)
		(!nmi_mask_reg && (par_chk_reg || io_chk_reg)) |=> nmi;
	endproperty
	a_nmi_follow: assert property (p_nmi_follow) else $error("nmi not raised");

	property p_fast_disabled;
		@(posedge clk_sys) disable iff (!rst_b)
		(io_req.wr && !fast_port_enable) |=> $stable(fast_port_reg);
	endproperty
	a_fast_disabled: assert property (p_fast_disabled)
		else $error("fast port written while off");

	property p_a20;
		@(posedge clk_sys) disable iff (!rst_b)
		fast_port_reg[atsc_pkg::FP_A20_BIT] |=> !addr_bit20_force_low_n;
	endproperty
	a_a20: assert property (p_a20) else $error("addr20 clamp not forced");

	property p_one_pulse;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(fast_busy) |-> $past(fast_arm);
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("reset pulse without arming");

	property p_kbc_sel;
		@(posedge clk_sys) disable iff (!rst_b)
		(io_req.wr && hit_kbc) |=> !kbc_select_n;
	endproperty
	a_kbc_sel: assert property (p_kbc_sel) else $error("kbc select missing");

	c_nmi: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(nmi));
	c_fast_reset: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(cpu_reset_out));
	c_parity: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(par_chk_reg));
endmodule
